// ---- rtl/rps_pkg.sv ----
// Constants and types for the resonant protection sequencer
package rps_pkg;
   localparam int CLK_PERIOD_PS          = 4000;
   localparam int OVERLOAD_BLANKING_PS   = 200000;
   localparam int OVERCURRENT_BLANKING_PS = 200000;
   localparam int ABNORMAL_BLANKING_PS   = 50000;
   // Least times round up to whole cycles
   localparam int OVERLOAD_BLANK_CYC     = (OVERLOAD_BLANKING_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int OVERCURRENT_BLANK_CYC  = (OVERCURRENT_BLANKING_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ABNORMAL_BLANK_CYC     = (ABNORMAL_BLANKING_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RESTART_SS_CYCLES      = 4;
   localparam int BLANK_W                = 8;

   typedef enum logic [1:0] {
      RPS_SS_IDLE,
      RPS_SS_FAST,
      RPS_SS_SLOW,
      RPS_SS_SINK
   } rps_ss_mode_t;

   typedef enum {
      RPS_ST_OFF,
      RPS_ST_START_FAST,
      RPS_ST_RUN,
      RPS_ST_RESTART,
      RPS_ST_LATCHED
   } rps_state_t;
endpackage : rps_pkg

// ---- rtl/rps_sync_if.sv ----
// Interface carrying synchronised comparator levels
`timescale 1ns/10ps
`default_nettype none
interface rps_sync_if;
   logic [10:0] level;
   modport src (output level);
   modport dst (input level);
endinterface : rps_sync_if
`default_nettype wire

// ---- rtl/rps_sync.sv ----
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module rps_sync
   import rps_pkg::*;
#(
   parameter int WIDTH = 11
)(
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] raw_i,
   rps_sync_if.src               sync_o
);
   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;
   logic [WIDTH-1:0] held;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta <= '0;
         s2   <= '0;
         s3   <= '0;
      end
      else
      begin
         meta <= raw_i;
         s2   <= meta;
         s3   <= s2;
      end
   end

   // Change counts only once stages two and three agree
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         held <= '0;
      else
         held <= (s2 & s3) | (held & (s2 | s3)); // RQ21
   end

   assign sync_o.level = held;
endmodule : rps_sync
`default_nettype wire

// ---- rtl/rps_blank.sv ----
// Blanking counter: asserts once input holds for CYCLES clocks
`timescale 1ns/10ps
`default_nettype none
module rps_blank
   import rps_pkg::*;
#(
   parameter int CYCLES = 50
)(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic level_i,
   output logic      hit_o
);
   logic [BLANK_W-1:0] count;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         count <= '0;
      else if (!level_i)
         count <= '0;
      else if (count != BLANK_W'(CYCLES))
         count <= count + BLANK_W'(1); // RQ21
   end

   assign hit_o = level_i && (count == BLANK_W'(CYCLES));
endmodule : rps_blank
`default_nettype wire

// ---- rtl/rps_sequencer.sv ----
// Protection sequencer top level
`timescale 1ns/10ps
`default_nettype none
// How it works
// RQ1: Overload held past blanking starts soft-start sink discharge.
// RQ2: A cycle without overload returns soft-start to fast charge.
// RQ3: Overload each cycle down to start level trips overload protection, gates off.
// RQ4: After overload trip, four soft-start charge/discharge cycles, then restart.
// RQ5: Over-current past blanking stops switching, four soft-start cycles, restart.
// RQ6: Abnormal current past short blanking stops switching at once.
// RQ7: Abnormal current trip discharges soft-start via internal switch.
// RQ8: Abnormal trip stays latched until low-side supply reaches release level; code also waits for it to rise back to start.
// RQ9: During soft-start use abnormal level for over-current, no abnormal latch.
// RQ10: Low-side supply at over-voltage level trips over-voltage protection.
// RQ11: Over-temperature trips latched thermal shutdown.
// RQ12: Line comparator high normally; hysteresis source on only when low.
// RQ13: Line recovery restarts switching through full soft-start.
// RQ14: Fault input above threshold stops switching at once, latched.
// RQ15: Line sense low locks out; high again starts with soft-start.
// RQ16: Feedback below lower level skips; above upper level resumes.
// RQ17: Overload, over-current, over-voltage, line lockout auto-restart; others latch.
// RQ18: Auto-restart stops both switches and retries after each delay.
// RQ19: Latch holds until supply falls to release then rises to start.
// RQ20: Startup fast-charges to start level, then slow current, gates on.
// RQ21: Comparators synchronised; blanking counted in whole cycles, rounded up.
module rps_sequencer
   import rps_pkg::*;
#(
   parameter int OL_BLANK  = OVERLOAD_BLANK_CYC,
   parameter int OC_BLANK  = OVERCURRENT_BLANK_CYC,
   parameter int AB_BLANK  = ABNORMAL_BLANK_CYC,
   parameter int SS_CYCLES = RESTART_SS_CYCLES
)(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic cs_overload_i,
   input  wire logic cs_overcurrent_i,
   input  wire logic cs_abnormal_i,
   input  wire logic supply_overvoltage_i,
   input  wire logic supply_release_i,
   input  wire logic supply_start_i,
   input  wire logic over_temp_i,
   input  wire logic fault_input_i,
   input  wire logic line_sense_high_i,
   input  wire logic feedback_below_low_i,
   input  wire logic feedback_above_high_i,
   input  wire logic ss_at_start_i,
   input  wire logic ss_at_end_i,
   input  wire logic ss_at_floor_i,
   input  wire logic switch_cycle_i,
   output logic      gate_enable_o,
   output logic      ss_fast_charge_o,
   output logic      ss_slow_charge_o,
   output logic      ss_sink_o,
   output logic      ss_discharge_o,
   output logic      line_hyst_enable_o,
   output logic      latched_fault_o,
   output logic      auto_restart_o
);
   localparam int SYNC_W = 11;

   rps_sync_if sync_bus ();

   logic       ol_lvl;
   logic       oc_lvl;
   logic       ab_lvl;
   logic       ov_lvl;
   logic       rel_lvl;
   logic       start_lvl;
   logic       temp_lvl;
   logic       fault_lvl;
   logic       line_lvl;
   logic       fb_low_lvl;
   logic       fb_high_lvl;
   logic       ol_hit;
   logic       oc_hit;
   logic       ab_hit;
   logic       in_soft_start;
   logic       oc_trip;
   logic       ab_trip;
   logic       latch_cause;
   logic       auto_cause;
   logic       skip;
   logic       sink_active;
   logic       ol_seen;
   logic       restore;
   logic       armed;
   logic       rel_seen;
   logic       cyc_dir_up;
   logic [3:0] cyc_count;
   logic       gate_q;
   logic       fast_q;
   logic       slow_q;
   logic       sink_q;
   logic       dis_q;
   logic       latch_q;
   logic       ar_q;
   logic       next_gate;
   logic       next_fast;
   logic       next_slow;
   logic       next_sink;
   logic       next_dis;
   logic       next_latch;
   logic       next_ar;
   rps_state_t state;
   rps_state_t next_state;

   rps_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .raw_i   ({feedback_above_high_i, feedback_below_low_i, line_sense_high_i,
                 fault_input_i, over_temp_i, supply_start_i, supply_release_i,
                 supply_overvoltage_i, cs_abnormal_i, cs_overcurrent_i, cs_overload_i}),
      .sync_o  (sync_bus)
   );

   assign {fb_high_lvl, fb_low_lvl, line_lvl, fault_lvl, temp_lvl, start_lvl, rel_lvl,
           ov_lvl, ab_lvl, oc_lvl, ol_lvl} = sync_bus.level;

   rps_blank #(.CYCLES(OL_BLANK)) u_ol_blank (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .level_i (ol_lvl),
      .hit_o   (ol_hit)
   );

   rps_blank #(.CYCLES(OC_BLANK)) u_oc_blank (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .level_i (oc_lvl),
      .hit_o   (oc_hit)
   );

   rps_blank #(.CYCLES(AB_BLANK)) u_ab_blank (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .level_i (ab_lvl),
      .hit_o   (ab_hit)
   );

   // Soft-start lasts from gate enable until end level
   assign in_soft_start = (state == RPS_ST_RUN) && !ss_at_end_i;

   // Abnormal level acts as auto-restart over-current during soft-start
   assign oc_trip = (state == RPS_ST_RUN) &&
                    (in_soft_start ? ab_hit : oc_hit); // RQ5 RQ9
   assign ab_trip = (state == RPS_ST_RUN) && !in_soft_start && ab_hit; // RQ6 RQ9

   assign latch_cause = ab_trip || temp_lvl || fault_lvl; // RQ11 RQ14 RQ17
   assign auto_cause  = ov_lvl || !line_lvl; // RQ10 RQ15 RQ17

   // Skip hysteresis; set wins so a noisy low level keeps gates off
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         skip <= 1'b0;
      else if (fb_low_lvl)
         skip <= 1'b1; // RQ16
      else if (fb_high_lvl)
         skip <= 1'b0; // RQ16
   end

   // Overload sink engages after blanking, tracked per switching cycle
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sink_active <= 1'b0;
         ol_seen     <= 1'b0;
         restore     <= 1'b0;
      end
      else if (state != RPS_ST_RUN)
      begin
         sink_active <= 1'b0;
         ol_seen     <= 1'b0;
         restore     <= 1'b0;
      end
      else if (switch_cycle_i)
      begin
         if (sink_active && !ol_seen && !ol_hit)
         begin
            sink_active <= 1'b0; // RQ2
            restore     <= 1'b1; // RQ2
         end
         else if (ss_at_end_i)
            restore <= 1'b0;
         ol_seen <= ol_hit;
      end
      else if (ol_hit)
      begin
         sink_active <= 1'b1; // RQ1
         ol_seen     <= 1'b1;
         restore     <= 1'b0;
      end
      // Restore ends at the end level; slow current carries on from there
      else if (ss_at_end_i)
         restore <= 1'b0;
   end

   // Latch release requires supply to fall to release then rise to start
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         rel_seen <= 1'b0;
      else if (state != RPS_ST_LATCHED)
         rel_seen <= 1'b0;
      else if (rel_lvl)
         rel_seen <= 1'b1; // RQ8 RQ19
   end

   // Start capture after supply good
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         armed <= 1'b0;
      else
         armed <= start_lvl;
   end

   // Restart delay: count full discharge/charge cycles of the soft-start capacitor
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cyc_dir_up <= 1'b0;
         cyc_count  <= '0;
      end
      else if (state != RPS_ST_RESTART)
      begin
         cyc_dir_up <= 1'b0;
         cyc_count  <= '0;
      end
      else if (!cyc_dir_up && ss_at_floor_i)
         cyc_dir_up <= 1'b1;
      else if (cyc_dir_up && ss_at_start_i)
      begin
         cyc_dir_up <= 1'b0;
         cyc_count  <= cyc_count + 4'h1; // RQ4 RQ5
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         RPS_ST_OFF:
            if (latch_cause)
               next_state = RPS_ST_LATCHED; // RQ11 RQ14
            else if (armed && line_lvl)
               next_state = RPS_ST_START_FAST; // RQ13 RQ15
         RPS_ST_START_FAST:
            if (latch_cause)
               next_state = RPS_ST_LATCHED;
            else if (auto_cause)
               next_state = RPS_ST_OFF;
            else if (ss_at_start_i)
               next_state = RPS_ST_RUN; // RQ20
         RPS_ST_RUN:
            if (latch_cause)
               next_state = RPS_ST_LATCHED; // RQ6 RQ14
            else if (oc_trip)
               next_state = RPS_ST_RESTART; // RQ5 RQ9
            else if (sink_active && ol_lvl && !ss_at_start_i)
               next_state = RPS_ST_RESTART; // RQ3
            else if (auto_cause)
               next_state = RPS_ST_OFF; // RQ18
         RPS_ST_RESTART:
            if (latch_cause)
               next_state = RPS_ST_LATCHED;
            else if (cyc_count == 4'(SS_CYCLES))
               next_state = RPS_ST_OFF; // RQ4 RQ18
         RPS_ST_LATCHED:
            if (rel_seen && start_lvl)
               next_state = RPS_ST_OFF; // RQ19
         default:
            next_state = RPS_ST_OFF;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         state <= RPS_ST_OFF;
      else
         state <= next_state;
   end

   // Current steering decoded from the state being entered
   always_comb
   begin
      next_gate  = 1'b0;
      next_fast  = 1'b0;
      next_slow  = 1'b0;
      next_sink  = 1'b0;
      next_dis   = 1'b0;
      next_latch = 1'b0;
      next_ar    = 1'b0;
      case (next_state)
         RPS_ST_OFF:
            next_dis = 1'b1; // RQ7
         RPS_ST_START_FAST:
            next_fast = 1'b1; // RQ20
         RPS_ST_RUN:
         begin
            next_gate = !skip; // RQ3 RQ16 RQ18
            next_sink = sink_active; // RQ1
            next_fast = !sink_active && (restore || !ss_at_start_i); // RQ2
            next_slow = !sink_active && !restore && ss_at_start_i; // RQ20
         end
         RPS_ST_RESTART:
         begin
            next_ar   = 1'b1; // RQ18
            next_fast = cyc_dir_up; // RQ4
            next_sink = !cyc_dir_up; // RQ4
         end
         RPS_ST_LATCHED:
         begin
            next_dis   = 1'b1; // RQ7
            next_latch = 1'b1; // RQ8
         end
         default:
            next_dis = 1'b1;
      endcase
   end

   // Outputs registered; glitch-free drive into the analogue current steering
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         gate_q  <= 1'b0;
         fast_q  <= 1'b0;
         slow_q  <= 1'b0;
         sink_q  <= 1'b0;
         dis_q   <= 1'b0;
         latch_q <= 1'b0;
         ar_q    <= 1'b0;
      end
      else
      begin
         gate_q  <= next_gate;
         fast_q  <= next_fast;
         slow_q  <= next_slow;
         sink_q  <= next_sink;
         dis_q   <= next_dis;
         latch_q <= next_latch;
         ar_q    <= next_ar;
      end
   end

   assign gate_enable_o      = gate_q;
   assign ss_fast_charge_o   = fast_q;
   assign ss_slow_charge_o   = slow_q;
   assign ss_sink_o          = sink_q;
   assign ss_discharge_o     = dis_q;
   assign line_hyst_enable_o = !line_lvl; // RQ12
   assign latched_fault_o    = latch_q;
   assign auto_restart_o     = ar_q;
endmodule : rps_sequencer
`default_nettype wire

// ---- sim/rps_partner.sv ----
// Soft-start capacitor and switching cycle model
`timescale 1ns/10ps
`default_nettype none
module rps_partner (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic gate_i,
   input  wire logic fast_i,
   input  wire logic slow_i,
   input  wire logic sink_i,
   input  wire logic dis_i,
   output logic      at_start_o,
   output logic      at_end_o,
   output logic      at_floor_o,
   output logic      pulse_o
);
   int v;
   int t;
   // Moves on the falling edge so the block samples settled levels
   always @(negedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         v <= 0;
         t <= 0;
      end
      else
      begin
         if (dis_i)
            v <= (v > 16) ? v - 16 : 0;
         else if (sink_i)
            v <= (v > 0) ? v - 1 : 0;
         else if (fast_i)
            v <= (v < 592) ? v + 8 : 600;
         else if (slow_i && v < 600)
            v <= v + 1;
         t <= (t == 19) ? 0 : t + 1;
      end
   end
   assign at_start_o = (v >= 160);
   assign at_end_o   = (v >= 420);
   assign at_floor_o = (v == 0);
   // No switching cycles while the gates are off
   assign pulse_o    = gate_i && (t == 0);
endmodule // rps_partner
`default_nettype wire

// ---- sim/rps_sequencer_assertions.sv ----
// Checker for the protection sequencer and its bind
`timescale 1ns/10ps
`default_nettype none
module rps_sequencer_assertions
   import rps_pkg::*;
#(
   parameter int OL_BLANK  = OVERLOAD_BLANK_CYC,
   parameter int OC_BLANK  = OVERCURRENT_BLANK_CYC,
   parameter int AB_BLANK  = ABNORMAL_BLANK_CYC,
   parameter int SS_CYCLES = RESTART_SS_CYCLES
)(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic cs_overload_i,
   input  wire logic cs_abnormal_i,
   input  wire logic supply_overvoltage_i,
   input  wire logic supply_release_i,
   input  wire logic over_temp_i,
   input  wire logic fault_input_i,
   input  wire logic line_sense_high_i,
   input  wire logic feedback_below_low_i,
   input  wire logic gate_enable_o,
   input  wire logic ss_sink_o,
   input  wire logic line_hyst_enable_o,
   input  wire logic latched_fault_o,
   input  wire logic auto_restart_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic [6:0] vec;
   logic [6:0] held [7];
   assign vec = {!supply_release_i, feedback_below_low_i, cs_overload_i,
      supply_overvoltage_i, over_temp_i, fault_input_i, cs_abnormal_i};
   // Saturating hold counts, so a long hold never wraps
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int k = 0; k < 7; k++)
            held[k] <= 7'h00;
      end
      else
      begin
         for (int k = 0; k < 7; k++)
         begin
            if (!vec[k])
               held[k] <= 7'h00;
            else if (held[k] != 7'h7f)
               held[k] <= held[k] + 7'h01;
         end
      end
   end
   // Over-current blanking is the longer one, so it bounds both paths
   abnormal_stop_a: assert property (held[0] == OC_BLANK + 12 |-> !gate_enable_o)
      else $error("abnormal current left gates on");
   fault_latch_a: assert property (held[1] == 12 |-> latched_fault_o && !gate_enable_o)
      else $error("fault input not latched");
   thermal_latch_a: assert property (held[2] == 12 |-> latched_fault_o)
      else $error("over temperature not latched");
   overvolt_stop_a: assert property (held[3] == 12 |-> !gate_enable_o)
      else $error("over voltage left gates on");
   overload_sink_a: assert property (held[4] == OL_BLANK + 12 && gate_enable_o |-> ss_sink_o)
      else $error("overload sink not started");
   skip_stop_a: assert property (held[5] == 12 |-> !gate_enable_o)
      else $error("skip did not stop gates");
   latch_hold_a: assert property (latched_fault_o && held[6] >= 12 |=> latched_fault_o)
      else $error("latch cleared without release");
   hyst_off_a: assert property (line_sense_high_i [*8] |-> !line_hyst_enable_o)
      else $error("hysteresis source on with line high");
   hyst_on_a: assert property (!line_sense_high_i [*8] |-> line_hyst_enable_o)
      else $error("hysteresis source off with line low");
   fault_gate_a: assert property (auto_restart_o || latched_fault_o |-> !gate_enable_o)
      else $error("gates on during protection");
   cover property ($rose(latched_fault_o));
   cover property ($rose(auto_restart_o));
   cover property ($fell(gate_enable_o) && feedback_below_low_i);
endmodule // rps_sequencer_assertions
bind rps_sequencer rps_sequencer_assertions #(.OL_BLANK(OL_BLANK), .OC_BLANK(OC_BLANK),
   .AB_BLANK(AB_BLANK), .SS_CYCLES(SS_CYCLES)) u_checker (.clk_i, .reset_i,
   .cs_overload_i, .cs_abnormal_i, .supply_overvoltage_i, .supply_release_i, .over_temp_i,
   .fault_input_i, .line_sense_high_i, .feedback_below_low_i, .gate_enable_o, .ss_sink_o,
   .line_hyst_enable_o, .latched_fault_o, .auto_restart_o);
`default_nettype wire

// ---- sim/test_rps_sequencer.sv ----
// Self-checking bench for the protection sequencer
`timescale 1ns/10ps
`default_nettype none
module test_rps_sequencer;
   localparam int HOLD = 20;
   localparam int SSC = 4;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ol = 1'b0, oc = 1'b0, ab = 1'b0, ov = 1'b0, rel = 1'b0, st = 1'b0;
   logic ot = 1'b0, flt = 1'b0, ln = 1'b0, fbl = 1'b0, fbh = 1'b1;
   logic at_start, at_end, at_floor, pulse;
   logic gate_enable_o, ss_fast_charge_o, ss_slow_charge_o, ss_sink_o;
   logic ss_discharge_o, line_hyst_enable_o, latched_fault_o, auto_restart_o;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #2 clk_i = ~clk_i;
   rps_sequencer #(.OL_BLANK(4), .OC_BLANK(4), .AB_BLANK(2), .SS_CYCLES(SSC)) dut (
      .clk_i, .reset_i, .cs_overload_i(ol), .cs_overcurrent_i(oc), .cs_abnormal_i(ab),
      .supply_overvoltage_i(ov), .supply_release_i(rel), .supply_start_i(st),
      .over_temp_i(ot), .fault_input_i(flt), .line_sense_high_i(ln),
      .feedback_below_low_i(fbl), .feedback_above_high_i(fbh), .ss_at_start_i(at_start),
      .ss_at_end_i(at_end), .ss_at_floor_i(at_floor), .switch_cycle_i(pulse),
      .gate_enable_o, .ss_fast_charge_o, .ss_slow_charge_o, .ss_sink_o,
      .ss_discharge_o, .line_hyst_enable_o, .latched_fault_o, .auto_restart_o);
   rps_partner u_far (.clk_i, .reset_i, .gate_i(gate_enable_o), .fast_i(ss_fast_charge_o),
      .slow_i(ss_slow_charge_o), .sink_i(ss_sink_o), .dis_i(ss_discharge_o),
      .at_start_o(at_start), .at_end_o(at_end), .at_floor_o(at_floor), .pulse_o(pulse));
   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string nm, input logic seen, input logic exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // Counts restart charge cycles while waiting for the gate level
   task automatic gate_wait(input logic lvl, input int lim, output int r);
      logic p;
      p = (ss_fast_charge_o === 1'b1);
      r = 0;
      for (int k = 0; k < lim && gate_enable_o !== lvl; k++)
      begin
         cyc(1);
         if (ss_fast_charge_o === 1'b1 && !p && auto_restart_o === 1'b1)
            r++;
         p = (ss_fast_charge_o === 1'b1);
      end
   endtask
   task automatic t_start();
      int r;
      {st, ln} = 2'h3;
      gate_wait(1'b1, 400, r);
      check("gate", gate_enable_o, 1'b1);
      check("slow", ss_slow_charge_o, 1'b1);
      check("hyst", line_hyst_enable_o, 1'b0);
   endtask
   task automatic t_overload();
      int r;
      logic f;
      cyc(300);
      ol = 1'b1;
      cyc(HOLD);
      check("sink", ss_sink_o, 1'b1);
      check("slow_off", ss_slow_charge_o, 1'b0);
      ol = 1'b0;
      f = 1'b0;
      // Two switching cycles plus synchroniser delay before the sink lets go
      for (int k = 0; k < 60; k++)
      begin
         cyc(1);
         f = f | (ss_fast_charge_o === 1'b1);
      end
      check("fast", f, 1'b1);
      ol = 1'b1;
      gate_wait(1'b0, 1500, r);
      check("ol_trip", gate_enable_o, 1'b0);
      check("ol_restart", auto_restart_o, 1'b1);
      ol = 1'b0;
      gate_wait(1'b1, 3000, r);
      check("ol_cycles", r == SSC, 1'b1);
   endtask
   task automatic t_overcurrent();
      int r;
      cyc(300);
      {ol, oc} = 2'h3;
      cyc(HOLD);
      check("oc_trip", gate_enable_o, 1'b0);
      check("oc_restart", auto_restart_o, 1'b1);
      {ol, oc} = 2'h0;
      gate_wait(1'b1, 3000, r);
      check("oc_cycles", r == SSC, 1'b1);
   endtask
   task automatic t_latch(input int k);
      int r;
      cyc(300);
      {ol, oc, ab} = (k == 0) ? 3'h7 : 3'h0;
      flt = (k == 1);
      ot = (k == 2);
      cyc(HOLD);
      check("gate", gate_enable_o, 1'b0);
      check("latched", latched_fault_o, 1'b1);
      if (k == 0)
         check("discharge", ss_discharge_o, 1'b1);
      {ol, oc, ab, flt, ot, st} = 6'h00;
      cyc(HOLD);
      st = 1'b1;
      cyc(HOLD);
      check("held", latched_fault_o, 1'b1);
      {rel, st} = 2'h2;
      cyc(HOLD);
      {rel, st} = 2'h1;
      gate_wait(1'b1, 500, r);
      check("unlatched", gate_enable_o, 1'b1);
   endtask
   // Runs right after a restart, while soft-start is still in progress
   task automatic t_soft();
      int r;
      oc = 1'b1;
      cyc(HOLD);
      check("soft_oc", gate_enable_o, 1'b1);
      ab = 1'b1;
      cyc(HOLD);
      check("soft_ab", gate_enable_o, 1'b0);
      check("no_latch", latched_fault_o, 1'b0);
      {oc, ab} = 2'h0;
      gate_wait(1'b1, 3000, r);
      check("retry", r == SSC, 1'b1);
   endtask
   task automatic t_line();
      int r;
      ln = 1'b0;
      cyc(HOLD);
      check("lockout", gate_enable_o, 1'b0);
      check("hyst_on", line_hyst_enable_o, 1'b1);
      ln = 1'b1;
      gate_wait(1'b1, 500, r);
      check("line_back", gate_enable_o, 1'b1);
      check("line_soft", ss_slow_charge_o, 1'b1);
   endtask
   task automatic t_skip();
      {fbl, fbh} = 2'h2;
      cyc(HOLD);
      check("skip", gate_enable_o, 1'b0);
      fbl = 1'b0;
      cyc(HOLD);
      check("band", gate_enable_o, 1'b0);
      fbh = 1'b1;
      cyc(HOLD);
      check("resume", gate_enable_o, 1'b1);
   endtask
   task automatic t_overvolt();
      int r;
      ov = 1'b1;
      cyc(HOLD);
      check("ov_stop", gate_enable_o, 1'b0);
      ov = 1'b0;
      gate_wait(1'b1, 3000, r);
      check("ov_back", gate_enable_o, 1'b1);
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         final_report();
      end
   end
   initial
   begin
      cyc(3);
      reset_i = 1'b0;
      cyc(2);
      t_start();
      t_overload();
      t_overcurrent();
      for (int k = 0; k < 3; k++)
         t_latch(k);
      t_soft();
      t_line();
      t_skip();
      t_overvolt();
      final_report();
   end
endmodule // test_rps_sequencer
`default_nettype wire
